// ### prcsc_device.sv
`timescale 1ns/1ps
// Function
// [RULE_01] each counter has 8-bit high and low
// [RULE_02] each counter has bypass and odd bits
// [RULE_03] bypass passes oscillator straight through
// [RULE_04] otherwise divide by high plus low
// [RULE_05] normal fall on oscillator rising edge
// [RULE_06] odd select falls on oscillator falling edge
// [RULE_07] chain is 144 bits, fully loaded
// [RULE_08] seven 18-bit groups plus two 9-bit fields
// [RULE_09] first bit is last counter low LSB
// [RULE_10] last bit is filter field MSB
// [RULE_11] pump code only 000 100 110 111
// [RULE_12] resistor code only listed eleven values
// [RULE_13] capacitor code only 00 01 11
// [RULE_14] bypass gives multiply or divide of one
// [RULE_15] bypass set ignores rest of group
// [RULE_16] enable rises a cycle before first bit
// [RULE_17] update pulse copies chain into settings
// [RULE_18] done high until every counter updated
// [RULE_19] fixed bit order inside each group
// [RULE_20] shift on scan rise while enabled
module prcsc_device
	import prcsc_pkg::*;
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// link
	prcsc_if.device                    lnk,
	// oscillator, and divided clocks one per chain group
	output logic                       osc_out,
	output logic [NUM_GROUPS-1:0]      div_out,
	// active analog codes
	output logic [PUMP_W-1:0]          pump_current_code,
	output logic [RES_W-1:0]           filter_resistor_code,
	output logic [CAP_W-1:0]           filter_capacitor_code,
	output logic                       code_error
);
	//==========================================================
	// scan edge detection
	logic                 sc_prev_q;
	logic                 ena_arm_q;
	logic                 upd_seen_q;
	logic                 scan_rise;
	logic                 commit_ev;
	logic [CHAIN_LEN-1:0] sr_q;
	logic [CHAIN_LEN-1:0] cfg_q;
	logic                 code_err_q;
	logic                 osc_q;
	logic                 done_q;
	logic [NUM_GROUPS-1:0] pend_v;

	assign scan_rise = lnk.scan_clk & ~sc_prev_q;
	assign commit_ev = scan_rise & lnk.update & ~upd_seen_q; // RULE_17

	always_ff @(posedge clk) begin
		if (rst) begin
			sc_prev_q <= 1'b0;
		end else begin
			sc_prev_q <= lnk.scan_clk;
		end
	end

	// first enabled rise only arms the chain
	always_ff @(posedge clk) begin
		if (rst) begin
			ena_arm_q  <= 1'b0;
			upd_seen_q <= 1'b0;
		end else if (scan_rise) begin
			ena_arm_q  <= lnk.scan_ena; // RULE_16
			upd_seen_q <= lnk.update;
		end
	end

	//==========================================================
	// scan register: first bit in ends at bit 0
	always_ff @(posedge clk) begin
		if (rst) begin
			sr_q <= '0;
		end else if (scan_rise && lnk.scan_ena && ena_arm_q) begin
			sr_q <= {lnk.scan_data, sr_q[CHAIN_LEN-1:1]}; // RULE_20
		end
	end

	//==========================================================
	// committed settings
	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_q <= CFG_RESET;
		end else if (commit_ev) begin
			cfg_q <= sr_q; // RULE_07
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			code_err_q <= 1'b0;
		end else if (commit_ev) begin
			code_err_q <= ~chain_ok(sr_q); // RULE_11 RULE_12 RULE_13
		end
	end

	// RULE_08 RULE_09 RULE_10
	assign pump_current_code     = cfg_q[PUMP_LSB +: PUMP_W];
	assign filter_resistor_code  = cfg_q[RES_LSB +: RES_W];
	assign filter_capacitor_code = cfg_q[CAP_LSB +: CAP_W];
	assign code_error            = code_err_q;

	//==========================================================
	// oscillator: each clk is half an oscillator cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			osc_q <= 1'b0;
		end else begin
			osc_q <= ~osc_q;
		end
	end

	assign osc_out = osc_q;

	//==========================================================
	// counters
	for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_cnt
		logic [GROUP_W-1:0] act_q;
		logic [GROUP_W-1:0] nxt;
		logic [CNT_W-1:0]   cnt_q;
		logic               hi_q;
		logic               out_q;
		logic               pend_q;
		logic               boundary;

		assign nxt = pend_q ? cfg_q[g*GROUP_W +: GROUP_W] : act_q;
		// period edge: the half cycle before the oscillator rises
		assign boundary = ~osc_q & (act_q[BYP_BIT]
			| (~hi_q & (cnt_q == 11'h001)));

		// new settings wait for the counter's own period edge
		always_ff @(posedge clk) begin
			if (rst) begin
				pend_q <= 1'b0;
			end else if (commit_ev) begin
				pend_q <= 1'b1;
			end else if (boundary) begin
				pend_q <= 1'b0;
			end
		end

		// active settings change only at a period edge
		always_ff @(posedge clk) begin
			if (rst) begin
				act_q <= GROUP_RESET;
			end else if (boundary) begin
				act_q <= nxt; // RULE_19
			end
		end

		// phase and half-cycle count; idle while bypassed
		always_ff @(posedge clk) begin
			if (rst) begin
				cnt_q <= 11'h001;
				hi_q  <= 1'b0;
			end else if (boundary) begin
				if (nxt[BYP_BIT]) begin
					hi_q  <= 1'b0; // RULE_15
					cnt_q <= 11'h001;
				end else begin
					hi_q  <= 1'b1; // RULE_01
					cnt_q <= half_len(nxt[HIGH_LSB +: 8], nxt[ODD_BIT],
						1'b0); // RULE_06
				end
			end else if (!act_q[BYP_BIT]) begin
				if (hi_q && cnt_q == 11'h001) begin
					hi_q  <= 1'b0;
					cnt_q <= half_len(act_q[LOW_LSB +: 8],
						act_q[ODD_BIT], 1'b1); // RULE_02
				end else if (cnt_q != 11'h001) begin
					cnt_q <= cnt_q - 11'h001;
				end
			end
		end

		// divided output: rises at each period edge
		always_ff @(posedge clk) begin
			if (rst) begin
				out_q <= 1'b0;
			end else if (boundary) begin
				out_q <= 1'b1;
			end else if (act_q[BYP_BIT]) begin
				out_q <= ~osc_q; // RULE_03 RULE_14
			end else if (hi_q && cnt_q == 11'h001) begin
				out_q <= 1'b0; // RULE_05 RULE_04
			end
		end

		assign div_out[g] = out_q;
		assign pend_v[g]  = pend_q;
	end

	//==========================================================
	// completion flag
	always_ff @(posedge clk) begin
		if (rst) begin
			done_q <= 1'b0;
		end else begin
			done_q <= commit_ev | (|pend_v); // RULE_18
		end
	end

	assign lnk.done = done_q;
endmodule : prcsc_device

// ### prcsc_if.sv
`timescale 1ns/1ps
//==============================================================
// serial reconfiguration link
interface prcsc_if;
	logic scan_clk;
	logic scan_ena;
	logic scan_data;
	logic update;
	logic done;

	modport loader (output scan_clk, scan_ena, scan_data, update,
		input done);
	modport device (input scan_clk, scan_ena, scan_data, update,
		output done);
endinterface : prcsc_if

// ### prcsc_loader.sv
`timescale 1ns/1ps
module prcsc_loader
	import prcsc_pkg::*;
#(
	parameter int SCAN_HALF = SCAN_HALF_CYC
)(
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 rst,
	// link
	prcsc_if.loader                   lnk,
	// user request
	input  wire logic                 start,
	input  wire logic [CHAIN_LEN-1:0] cfg,
	// user status
	output logic                      busy,
	output logic                      finished,
	output logic                      rejected
);
	typedef enum logic [2:0] {
		LD_IDLE, LD_LEAD, LD_ARM, LD_SHIFT,
		LD_UPD, LD_UPDH, LD_WHI, LD_WLO
	} prcsc_ld_t;

	prcsc_ld_t            st_q;
	logic [7:0]           hc_q;
	logic                 sclk_q;
	logic                 fall_ev;
	logic [CHAIN_LEN-1:0] cfg_q;
	logic [7:0]           cnt_q;
	logic                 ena_q;
	logic                 data_q;
	logic                 upd_q;
	logic                 seen_q;
	logic                 busy_q;
	logic                 fin_q;
	logic                 rej_q;

	//==========================================================
	// scan clock divider, free running
	assign fall_ev = (hc_q == 8'(SCAN_HALF - 1)) & sclk_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			hc_q   <= 8'h00;
			sclk_q <= 1'b0;
		end else if (hc_q == 8'(SCAN_HALF - 1)) begin
			hc_q   <= 8'h00;
			sclk_q <= ~sclk_q;
		end else begin
			hc_q <= hc_q + 8'h01;
		end
	end

	//==========================================================
	// done seen since the load left idle
	always_ff @(posedge clk) begin
		if (rst || st_q == LD_IDLE) begin
			seen_q <= 1'b0;
		end else if (lnk.done) begin
			seen_q <= 1'b1;
		end
	end

	//==========================================================
	// sequence; link outputs change on scan falling edges
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q   <= LD_IDLE;
			cfg_q  <= '0;
			cnt_q  <= 8'h00;
			ena_q  <= 1'b0;
			data_q <= 1'b0;
			upd_q  <= 1'b0;
			busy_q <= 1'b0;
			fin_q  <= 1'b0;
			rej_q  <= 1'b0;
		end else begin
			fin_q <= 1'b0;
			rej_q <= 1'b0;
			unique case (st_q)
				LD_IDLE: begin
					if (start && chain_ok(cfg)) begin // RULE_11 RULE_12
						cfg_q  <= cfg;
						busy_q <= 1'b1;
						st_q   <= LD_LEAD;
					end else if (start) begin // RULE_13
						rej_q <= 1'b1;
					end
				end
				LD_LEAD: begin
					if (fall_ev) begin
						ena_q  <= 1'b1; // RULE_16
						data_q <= cfg_q[0]; // RULE_09
						st_q   <= LD_ARM;
					end
				end
				LD_ARM: begin
					if (fall_ev) begin
						cnt_q <= 8'h00;
						st_q  <= LD_SHIFT;
					end
				end
				LD_SHIFT: begin
					if (fall_ev) begin
						if (cnt_q == 8'(CHAIN_LEN - 1)) begin // RULE_07
							ena_q  <= 1'b0; // RULE_10
							data_q <= 1'b0;
							st_q   <= LD_UPD;
						end else begin
							cnt_q  <= cnt_q + 8'h01;
							cfg_q  <= {1'b0, cfg_q[CHAIN_LEN-1:1]};
							data_q <= cfg_q[1];
						end
					end
				end
				LD_UPD: begin
					if (fall_ev) begin
						upd_q <= 1'b1; // RULE_17
						st_q  <= LD_UPDH;
					end
				end
				LD_UPDH: begin
					if (fall_ev) begin
						upd_q <= 1'b0;
						st_q  <= LD_WHI;
					end
				end
				LD_WHI: begin
					if (seen_q) begin
						st_q <= LD_WLO;
					end
				end
				LD_WLO: begin
					if (!lnk.done) begin // RULE_18
						busy_q <= 1'b0;
						fin_q  <= 1'b1;
						st_q   <= LD_IDLE;
					end
				end
			endcase
		end
	end

	assign lnk.scan_clk  = sclk_q;
	assign lnk.scan_ena  = ena_q;
	assign lnk.scan_data = data_q;
	assign lnk.update    = upd_q;
	assign busy          = busy_q;
	assign finished      = fin_q;
	assign rejected      = rej_q;
endmodule : prcsc_loader

// ### prcsc_pkg.sv
//==============================================================
// scan chain geometry, reset values and timing
package prcsc_pkg;
	localparam int CHAIN_LEN  = 144;
	localparam int GROUP_W    = 18;
	localparam int NUM_GROUPS = 7;
	localparam int NUM_OUT    = 5;
	localparam int FIELD_W    = 9;
	localparam int CNT_W      = 11;
	// group bit positions, serial order low count first
	localparam int LOW_LSB    = 0;
	localparam int BYP_BIT    = 8;
	localparam int HIGH_LSB   = 9;
	localparam int ODD_BIT    = 17;
	// analog fields after the seven counter groups
	localparam int PUMP_LSB   = 126;
	localparam int FILT_LSB   = 135;
	localparam int RES_LSB    = 135;
	localparam int CAP_LSB    = 140;
	localparam int PUMP_W     = 3;
	localparam int RES_W      = 5;
	localparam int CAP_W      = 2;
	// reset: every counter bypassed, counts of one
	localparam logic [GROUP_W-1:0] GROUP_RESET = 18'h00301;
	localparam logic [2*FIELD_W-1:0] FIELD_RESET = 18'h00000;
	localparam logic [CHAIN_LEN-1:0] CFG_RESET =
		{FIELD_RESET, {NUM_GROUPS{GROUP_RESET}}};
	// scan clock at most 100 MHz on a 200 MHz system clock
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SCAN_MIN_PERIOD_PS = 10000;
	localparam int SCAN_HALF_CYC =
		(SCAN_MIN_PERIOD_PS + 2 * CLK_PERIOD_PS - 1) / (2 * CLK_PERIOD_PS);

	//==========================================================
	// legal codes
	function automatic logic pump_ok(input logic [PUMP_W-1:0] c);
		return (c == 3'h0) || (c == 3'h4) || (c == 3'h6) || (c == 3'h7);
	endfunction : pump_ok

	function automatic logic res_ok(input logic [RES_W-1:0] c);
		logic [3:0] lo;
		lo = c[3:0];
		return (lo == 4'h0) || (lo == 4'h3) || (lo == 4'h4)
			|| (lo == 4'h8) || (c == 5'h1B) || (c == 5'h1C)
			|| (c == 5'h1E);
	endfunction : res_ok

	function automatic logic cap_ok(input logic [CAP_W-1:0] c);
		return c != 2'h2;
	endfunction : cap_ok

	function automatic logic chain_ok(input logic [CHAIN_LEN-1:0] v);
		return pump_ok(v[PUMP_LSB +: PUMP_W]) && res_ok(v[RES_LSB +: RES_W])
			&& cap_ok(v[CAP_LSB +: CAP_W]);
	endfunction : chain_ok

	//==========================================================
	// half oscillator cycles of one phase; count 0 means 256
	function automatic logic [CNT_W-1:0] half_len(
		input logic [7:0] c, input logic odd, input logic up);
		logic [CNT_W-1:0] base;
		base = {1'b0, (c == 8'h00), c, 1'b0};
		return up ? base + {10'h000, odd} : base - {10'h000, odd};
	endfunction : half_len
endpackage : prcsc_pkg

// ### prcsc_sva.sv
`timescale 1ns/1ps
module prcsc_sva (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// link
	input  wire logic scan_clk,
	input  wire logic scan_ena,
	input  wire logic scan_data,
	input  wire logic update,
	input  wire logic done
);
	logic        sclk_q;
	logic [7:0]  shift_q;
	logic [10:0] busy_q;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	//==========================================================
	// helper counters
	always_ff @(posedge clk) begin
		sclk_q <= scan_clk;
	end

	// arm rise plus shifting rises while enabled
	always_ff @(posedge clk) begin
		if (rst || !scan_ena) begin
			shift_q <= 8'h00;
		end else if (scan_clk && !sclk_q) begin
			shift_q <= shift_q + 8'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || !done) begin
			busy_q <= 11'h000;
		end else begin
			busy_q <= busy_q + 11'h001;
		end
	end

	//==========================================================
	// link rules
	a_data_on_fall: assert property (
		$changed(scan_data) |-> $fell(scan_clk))
		else $error("scan data moved off a scan clock fall");
	a_ena_on_fall: assert property (
		$changed(scan_ena) |-> $fell(scan_clk))
		else $error("enable moved off a scan clock fall");
	a_update_on_fall: assert property (
		$rose(update) |-> $fell(scan_clk))
		else $error("update rose off a scan clock fall");
	a_update_no_ena: assert property (
		update |-> !scan_ena)
		else $error("update while shifting enabled");
	a_update_width: assert property (
		$rose(update) |=> update ##1 !update)
		else $error("update not held one scan period");
	a_shift_count: assert property (
		$fell(scan_ena) |-> shift_q == 8'h91)
		else $error("wrong number of shifting rises");
	a_done_after: assert property (
		$rose(update) |-> ##[1:6] done)
		else $error("done did not follow commit");
	a_done_bounded: assert property (
		done |-> busy_q < 11'h4B0)
		else $error("done held too long");
endmodule : prcsc_sva

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import prcsc_pkg::*;
	logic                  clk, rst, start, busy, finished, rejected;
	logic [CHAIN_LEN-1:0]  cfg;
	logic                  osc_out, code_error;
	logic [NUM_GROUPS-1:0] div_out;
	logic [PUMP_W-1:0]     pump;
	logic [RES_W-1:0]      res;
	logic [CAP_W-1:0]      cap;
	logic [9:0]            last = 10'h000;
	logic [10:0]           exp_q[$];
	int                    fail_count = 0;
	int                    n_compared = 0;
	int                    cyc = 0;

	prcsc_if lnk ();
	prcsc_loader prcsc_loader_inst (.clk(clk), .rst(rst), .lnk(lnk),
		.start(start), .cfg(cfg), .busy(busy), .finished(finished),
		.rejected(rejected));
	prcsc_device prcsc_device_inst (.clk(clk), .rst(rst), .lnk(lnk),
		.osc_out(osc_out), .div_out(div_out), .pump_current_code(pump),
		.filter_resistor_code(res), .filter_capacitor_code(cap),
		.code_error(code_error));
	prcsc_sva prcsc_sva_inst (.clk(clk), .rst(rst),
		.scan_clk(lnk.scan_clk), .scan_ena(lnk.scan_ena),
		.scan_data(lnk.scan_data), .update(lnk.update), .done(lnk.done));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	//==========================================================
	// checking and closing
	task automatic check(input logic [10:0] seen, input logic [10:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test

	// committed codes and refusals, oldest note first
	always @(negedge clk) begin
		cyc++;
		if (finished === 1'b1 || rejected === 1'b1) begin
			check({rejected, cap, res, pump}, exp_q.pop_front());
		end
		if (cyc > 90000) begin
			fail_count++;
			finish_test();
		end
	end

	//==========================================================
	// one full load; g0 is the last output counter group
	task automatic load(input logic [2:0] p, input logic [4:0] r,
		input logic [1:0] c, input logic [17:0] g0, input logic byp);
		logic [CHAIN_LEN-1:0] v;
		logic                 ok;
		int                   k;
		for (int g = 1; g < NUM_GROUPS; g++)
			v[18*g +: 18] = 18'($urandom) | {9'h000, byp, 8'h00};
		v[17:0] = g0;
		v[PUMP_LSB +: 9] = {6'($urandom), p};
		v[FILT_LSB +: 9] = {2'($urandom), c, r};
		ok = (p inside {3'h0, 3'h4, 3'h6, 3'h7}) && (c != 2'h2)
			&& (r inside {5'h00, 5'h03, 5'h04, 5'h08, 5'h10, 5'h13, 5'h14,
			5'h18, 5'h1B, 5'h1C, 5'h1E});
		if (ok)
			last = {c, r, p};
		exp_q.push_back({!ok, last});
		cfg <= v;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		@(negedge clk);
		check({10'h000, busy}, {10'h000, ok});
		k = 0;
		while (finished !== 1'b1 && rejected !== 1'b1 && k < 5000) begin
			@(negedge clk);
			k++;
		end
		// a load that never ends counts as a mismatch
		if (k >= 5000)
			fail_count++;
		@(posedge clk);
	endtask : load

	// one full period of a divided output, in clk cycles
	task automatic meas(input int g, input int hi_e, input int lo_e);
		int k, hi, lo;
		k = 0;
		hi = 0;
		lo = 0;
		while (div_out[g] !== 1'b0 && k < 3000) begin
			@(negedge clk);
			k++;
		end
		while (div_out[g] !== 1'b1 && k < 3000) begin
			@(negedge clk);
			k++;
		end
		while (div_out[g] === 1'b1 && k < 3000) begin
			@(negedge clk);
			k++;
			hi++;
		end
		while (div_out[g] === 1'b0 && k < 3000) begin
			@(negedge clk);
			k++;
			lo++;
		end
		check(11'(hi), 11'(hi_e));
		check(11'(lo), 11'(lo_e));
	endtask : meas

	//==========================================================
	// main sequence
	initial begin
		static logic [2:0] pc[4] = '{3'h0, 3'h4, 3'h6, 3'h7};
		static logic [4:0] rc[11] = '{5'h00, 5'h03, 5'h04, 5'h08, 5'h10,
			5'h13, 5'h14, 5'h18, 5'h1B, 5'h1C, 5'h1E};
		static logic [1:0] cc[3] = '{2'h0, 2'h1, 2'h3};
		logic [7:0] h, l;
		logic       o;
		rst = 1'b1;
		start = 1'b0;
		cfg = '0;
		void'($urandom(6283));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (pc[i]) load(pc[i], 5'h00, 2'h0, 18'h00301, 1'b0);
		foreach (rc[i]) load(3'h4, rc[i], 2'h1, 18'h00301, 1'b0);
		foreach (cc[i]) load(3'h6, 5'h03, cc[i], 18'h00301, 1'b0);
		load(3'h1, 5'h00, 2'h0, 18'h00301, 1'b0);
		load(3'h0, 5'h01, 2'h0, 18'h00301, 1'b0);
		load(3'h0, 5'h00, 2'h2, 18'h00301, 1'b0);
		for (int i = 0; i < 6; i++) begin
			h = 8'(1 + $urandom % 8);
			l = 8'(1 + $urandom % 8);
			load(3'h7, 5'h1E, 2'h3, {i[0], h, 1'b0, l}, 1'b0);
			meas(0, 2 * h - i[0], 2 * l + i[0]);
		end
		load(3'h0, 5'h00, 2'h0, 18'($urandom) | 18'h00100, 1'b1);
		check({10'h000, code_error}, 11'h000);
		for (int g = 0; g < NUM_GROUPS; g++) begin
			@(negedge clk);
			o = osc_out;
			@(negedge clk);
			check({10'h000, osc_out}, {10'h000, ~o});
			check({10'h000, div_out[g]}, {10'h000, osc_out});
		end
		// every noted result must have been seen
		check(11'(exp_q.size()), 11'h000);
		finish_test();
	end
endmodule : tb_top
